// *** design/msv_multi_speed_vf.sv ***
// Multi-speed frequency selection and V/F pattern shaping with an Avalon-MM register slave.
// ============================================================================
// Overview of operation
// - Pattern 0 gives voltage linear in frequency up to base frequency.
// - Pattern 1 gives voltage square-law in frequency up to base frequency.
// - Pattern 2 applies boost in forward rotation, zero boost in reverse.
// - Pattern 3 applies boost in reverse rotation, zero boost in forward.
// - Second-function input selects the second torque boost instead of the primary.
// - Either flux vector control mode makes the load pattern ignored.
// - Load pattern resets to 0, the linear constant-torque pattern.
// - High, middle and low select inputs pick the high, middle, low presets.
// - High, middle and low presets reset to 60, 30 and 10 Hz.
// - Several basic selects on and their combination preset at 9999: the lowest-ranked active input's preset wins.
// - Speeds 4 to 15 come from four-input combinations, each own preset.
// - Preset 9999 means not selected; speeds 4 to 15 reset to 9999.
// - Speed 8 invalid with extension alone on runs at the low preset.
// - Remote function selection nonzero disables multi-speed selection.
// - Assignment codes 0, 1, 2 map to low, middle, high select inputs.
// - Assignment code 8 routes the extension select input to its terminal.
// - Assignment code 3 routes the second-function input to its terminal.
// - Preset writes are always accepted, whatever the parameter write selection.
// - Load pattern and speed 4-15 presets accessible only with user group 0.
// - Base frequency is the curve knee, resets to 60 Hz, configurable.
`timescale 1ns/1ps
module msv_multi_speed_vf (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [4:0] virtual_terminal,
  input wire logic forward_run,
  input wire logic reverse_run,
  output logic [15:0] freq_cmd,
  output logic [3:0] speed_index,
  output logic multi_speed_active,
  output logic [9:0] voltage_cmd
);
  // ==========================================================================
  // Functions.
  // Tells whether any virtual terminal that is on carries the given function code.
  function automatic logic term_has(input logic [19:0] assign_map, input logic [4:0] terms,
                                    input logic [3:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < msv_pkg::NUM_TERMINALS; i++) begin
      if (assign_map[4*i +: 4] == code && terms[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : term_has

  // Fixed table from {extension, high, middle, low} to speeds 4 to 15; zero when none.
  function automatic logic [3:0] combo_speed(input logic [3:0] combo);
    logic [3:0] sp;
    case (combo)
      4'h6: sp = 4'h4;
      4'h5: sp = 4'h5;
      4'h3: sp = 4'h6;
      4'h7: sp = 4'h7;
      4'h8: sp = 4'h8;
      4'h9: sp = 4'h9;
      4'ha: sp = 4'ha;
      4'hb: sp = 4'hb;
      4'hc: sp = 4'hc;
      4'hd: sp = 4'hd;
      4'he: sp = 4'he;
      4'hf: sp = 4'hf;
      default: sp = 4'h0;
    endcase
    return sp;
  endfunction : combo_speed

  // Gives the preset number addressed, or zero when the address is no preset.
  function automatic logic [3:0] preset_at(input logic [7:0] addr);
    logic [3:0] n;
    n = 4'h0;
    if (addr >= msv_pkg::OFS_PRESET_BASE + 8'h04 && addr <= msv_pkg::OFS_PRESET_BASE + 8'h3c
        && addr[1:0] == 2'h0) begin
      n = addr[5:2];
    end
    return n;
  endfunction : preset_at

  // Merges the low two write bytes into a 16-bit value under the byte enables.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : merge16

  // ==========================================================================
  // Registers.
  logic [1:0] load_pattern_setting_reg;
  logic [1:0] control_mode_reg;
  logic [1:0] remote_function_selection_reg;
  logic [15:0] user_group_read_selection_reg;
  logic [1:0] parameter_write_selection_reg;
  logic [9:0] primary_torque_boost_reg;
  logic [9:0] second_torque_boost_reg;
  logic [15:0] base_frequency_setting_reg;
  logic [19:0] input_function_assignment_reg;
  logic [15:0] preset_reg [1:15];
  logic accept;
  logic wr_now;
  logic user_open;
  logic params_open;
  logic [3:0] wr_preset;
  logic [15:0] preset_merged;
  logic [15:0] base_merged;

  assign accept = (avs_read || avs_write) && avs_waitrequest;
  assign wr_now = accept && avs_write;
  assign user_open = (user_group_read_selection_reg == 16'h0000);
  assign params_open = (parameter_write_selection_reg != msv_pkg::PWS_LOCKED);
  assign wr_preset = preset_at(avs_address);
  assign preset_merged = merge16(preset_reg[(wr_preset == 4'h0) ? 4'h1 : wr_preset], avs_writedata,
                                 avs_byteenable);
  assign base_merged = merge16(base_frequency_setting_reg, avs_writedata, avs_byteenable);

  // ==========================================================================
  // Bus handshake: one wait cycle, then one cycle with waitrequest low.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !accept;
    end
  end

  // ==========================================================================
  // Multi-speed presets.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      preset_reg[1] <= msv_pkg::RST_HIGH_SPEED;
      preset_reg[2] <= msv_pkg::RST_MIDDLE_SPEED;
      preset_reg[3] <= msv_pkg::RST_LOW_SPEED;
      for (int i = 4; i < 16; i++) begin
        preset_reg[i] <= msv_pkg::FREQ_INVALID;
      end
    end else if (wr_now && wr_preset != 4'h0 && (wr_preset < 4'h4 || user_open)) begin
      preset_reg[wr_preset] <= preset_merged;
    end
  end

  // ==========================================================================
  // Parameter registers.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      load_pattern_setting_reg <= msv_pkg::RST_LOAD_PATTERN;
      control_mode_reg <= msv_pkg::MODE_VF;
      remote_function_selection_reg <= 2'h0;
      user_group_read_selection_reg <= 16'h0000;
      parameter_write_selection_reg <= 2'h0;
      primary_torque_boost_reg <= msv_pkg::RST_PRIMARY_BOOST;
      second_torque_boost_reg <= msv_pkg::RST_SECOND_BOOST;
      base_frequency_setting_reg <= msv_pkg::RST_BASE_FREQ;
      input_function_assignment_reg <= msv_pkg::RST_INPUT_ASSIGN;
    end else if (wr_now) begin
      if (avs_address == msv_pkg::OFS_PARAM_WRITE && avs_byteenable[0]) begin
        parameter_write_selection_reg <= avs_writedata[1:0];
      end
      if (avs_address == msv_pkg::OFS_USER_GROUP) begin
        user_group_read_selection_reg <= merge16(user_group_read_selection_reg, avs_writedata, avs_byteenable);
      end
      if (params_open && avs_byteenable[0]) begin
        case (avs_address)
          msv_pkg::OFS_LOAD_PATTERN: begin
            if (user_open) begin
              load_pattern_setting_reg <= avs_writedata[1:0];
            end
          end
          msv_pkg::OFS_CONTROL_MODE: control_mode_reg <= avs_writedata[1:0];
          msv_pkg::OFS_REMOTE_FUNC: remote_function_selection_reg <= avs_writedata[1:0];
          msv_pkg::OFS_PRIMARY_BOOST: primary_torque_boost_reg <= avs_writedata[9:0];
          msv_pkg::OFS_SECOND_BOOST: second_torque_boost_reg <= avs_writedata[9:0];
          msv_pkg::OFS_BASE_FREQ: base_frequency_setting_reg <= base_merged;
          msv_pkg::OFS_INPUT_ASSIGN: input_function_assignment_reg <= avs_writedata[19:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Read data, captured when the request is accepted.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (accept && avs_read) begin
      if (wr_preset != 4'h0) begin
        avs_readdata <= (wr_preset < 4'h4 || user_open) ? {16'h0000, preset_reg[wr_preset]} : 32'h00000000;
      end else begin
        case (avs_address)
          msv_pkg::OFS_LOAD_PATTERN: avs_readdata <= user_open ? {30'h0, load_pattern_setting_reg} : 32'h0;
          msv_pkg::OFS_CONTROL_MODE: avs_readdata <= {30'h0, control_mode_reg};
          msv_pkg::OFS_REMOTE_FUNC: avs_readdata <= {30'h0, remote_function_selection_reg};
          msv_pkg::OFS_USER_GROUP: avs_readdata <= {16'h0, user_group_read_selection_reg};
          msv_pkg::OFS_PARAM_WRITE: avs_readdata <= {30'h0, parameter_write_selection_reg};
          msv_pkg::OFS_PRIMARY_BOOST: avs_readdata <= {22'h0, primary_torque_boost_reg};
          msv_pkg::OFS_SECOND_BOOST: avs_readdata <= {22'h0, second_torque_boost_reg};
          msv_pkg::OFS_BASE_FREQ: avs_readdata <= {16'h0, base_frequency_setting_reg};
          msv_pkg::OFS_INPUT_ASSIGN: avs_readdata <= {12'h0, input_function_assignment_reg};
          msv_pkg::OFS_STATUS: avs_readdata <= {11'h0, multi_speed_active, speed_index, freq_cmd};
          msv_pkg::OFS_VOLTAGE: avs_readdata <= {22'h0, voltage_cmd};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Speed selection.
  logic low_speed_select;
  logic middle_speed_select;
  logic high_speed_select;
  logic speed_extension_select;
  logic second_function_select;
  logic [3:0] combo_idx;
  logic [3:0] basic_idx;
  logic [3:0] speed_next;
  logic [15:0] freq_next;

  assign low_speed_select = term_has(input_function_assignment_reg, virtual_terminal, msv_pkg::CODE_LOW);
  assign middle_speed_select = term_has(input_function_assignment_reg, virtual_terminal,
                                        msv_pkg::CODE_MIDDLE);
  assign high_speed_select = term_has(input_function_assignment_reg, virtual_terminal, msv_pkg::CODE_HIGH);
  assign speed_extension_select = term_has(input_function_assignment_reg, virtual_terminal,
                                           msv_pkg::CODE_EXTENSION);
  assign second_function_select = term_has(input_function_assignment_reg, virtual_terminal,
                                           msv_pkg::CODE_SECOND);

  always_comb begin
    combo_idx = combo_speed({speed_extension_select, high_speed_select, middle_speed_select,
                             low_speed_select});
    if (low_speed_select) begin
      basic_idx = 4'h3;
    end else if (middle_speed_select) begin
      basic_idx = 4'h2;
    end else if (high_speed_select) begin
      basic_idx = 4'h1;
    end else begin
      basic_idx = 4'h0;
    end
    if (remote_function_selection_reg != 2'h0) begin
      speed_next = 4'h0;
    end else if (combo_idx != 4'h0 && preset_reg[(combo_idx == 4'h0) ? 4'h1 : combo_idx] != msv_pkg::FREQ_INVALID) begin
      speed_next = combo_idx;
    end else if (combo_idx == 4'h8) begin
      speed_next = 4'h3;
    end else begin
      speed_next = basic_idx;
    end
    freq_next = (speed_next == 4'h0) ? 16'h0000 : preset_reg[(speed_next == 4'h0) ? 4'h1 : speed_next];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      freq_cmd <= 16'h0000;
      speed_index <= 4'h0;
      multi_speed_active <= 1'b0;
    end else begin
      freq_cmd <= freq_next;
      speed_index <= speed_next;
      multi_speed_active <= (speed_next != 4'h0);
    end
  end

  // ==========================================================================
  // V/F curve.
  logic [1:0] eff_pattern;
  logic [31:0] ratio;
  logic [31:0] curve;
  logic [31:0] boost;
  logic [31:0] volt;

  always_comb begin
    if (control_mode_reg == msv_pkg::MODE_FLUX_ADV || control_mode_reg == msv_pkg::MODE_FLUX_GEN) begin
      eff_pattern = msv_pkg::PAT_LINEAR;
    end else begin
      eff_pattern = load_pattern_setting_reg;
    end
    if (base_frequency_setting_reg == 16'h0000 || freq_next >= base_frequency_setting_reg) begin
      ratio = msv_pkg::FULL_SCALE;
    end else begin
      ratio = ({16'h0000, freq_next} * msv_pkg::FULL_SCALE) / {16'h0000, base_frequency_setting_reg};
    end
    if (eff_pattern == msv_pkg::PAT_SQUARE) begin
      curve = (ratio * ratio) / msv_pkg::FULL_SCALE;
    end else begin
      curve = ratio;
    end
    boost = {22'h0, second_function_select ? second_torque_boost_reg : primary_torque_boost_reg};
    if (boost > msv_pkg::FULL_SCALE) begin
      boost = msv_pkg::FULL_SCALE;
    end
    if (eff_pattern == msv_pkg::PAT_LIFT_FWD && reverse_run) begin
      boost = 32'h00000000;
    end
    if (eff_pattern == msv_pkg::PAT_LIFT_REV && forward_run) begin
      boost = 32'h00000000;
    end
    volt = boost + (curve * (msv_pkg::FULL_SCALE - boost)) / msv_pkg::FULL_SCALE;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      voltage_cmd <= 10'h000;
    end else begin
      voltage_cmd <= volt[9:0];
    end
  end
endmodule : msv_multi_speed_vf

// *** pkg/msv_pkg.sv ***
// Package with register map, reset values and codes of the multi-speed and V/F pattern block.
package msv_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_LOAD_PATTERN = 8'h00;
  localparam logic [7:0] OFS_CONTROL_MODE = 8'h04;
  localparam logic [7:0] OFS_REMOTE_FUNC = 8'h08;
  localparam logic [7:0] OFS_USER_GROUP = 8'h0c;
  localparam logic [7:0] OFS_PARAM_WRITE = 8'h10;
  localparam logic [7:0] OFS_PRIMARY_BOOST = 8'h14;
  localparam logic [7:0] OFS_SECOND_BOOST = 8'h18;
  localparam logic [7:0] OFS_BASE_FREQ = 8'h1c;
  localparam logic [7:0] OFS_INPUT_ASSIGN = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_VOLTAGE = 8'h2c;
  // Preset of speed n sits at OFS_PRESET_BASE + 4*n, n = 1 (high) to 15.
  localparam logic [7:0] OFS_PRESET_BASE = 8'h40;
  // ==========================================================================
  // Values after reset; frequencies in units of 0.1 Hz.
  localparam logic [15:0] FREQ_INVALID = 16'h270f;
  localparam logic [15:0] RST_HIGH_SPEED = 16'h0258;
  localparam logic [15:0] RST_MIDDLE_SPEED = 16'h012c;
  localparam logic [15:0] RST_LOW_SPEED = 16'h0064;
  localparam logic [15:0] RST_BASE_FREQ = 16'h0258;
  localparam logic [1:0] RST_LOAD_PATTERN = 2'h0;
  localparam logic [9:0] RST_PRIMARY_BOOST = 10'h03c;
  localparam logic [9:0] RST_SECOND_BOOST = 10'h03c;
  localparam logic [19:0] RST_INPUT_ASSIGN = 20'h83210;
  // ==========================================================================
  // Load patterns, control modes and input function codes.
  localparam logic [1:0] PAT_LINEAR = 2'h0;
  localparam logic [1:0] PAT_SQUARE = 2'h1;
  localparam logic [1:0] PAT_LIFT_FWD = 2'h2;
  localparam logic [1:0] PAT_LIFT_REV = 2'h3;
  localparam logic [1:0] MODE_VF = 2'h0;
  localparam logic [1:0] MODE_FLUX_ADV = 2'h1;
  localparam logic [1:0] MODE_FLUX_GEN = 2'h2;
  localparam logic [3:0] CODE_LOW = 4'h0;
  localparam logic [3:0] CODE_MIDDLE = 4'h1;
  localparam logic [3:0] CODE_HIGH = 4'h2;
  localparam logic [3:0] CODE_SECOND = 4'h3;
  localparam logic [3:0] CODE_EXTENSION = 4'h8;
  localparam logic [1:0] PWS_LOCKED = 2'h1;
  localparam int NUM_TERMINALS = 5;
  // Full scale of voltage and boost, in per-mille.
  localparam logic [31:0] FULL_SCALE = 32'h000003e8;
endpackage : msv_pkg

// *** tb/msv_fieldbus_model.sv ***
// Fieldbus master model that refreshes the virtual input terminals.
`timescale 1ns/1ps
module msv_fieldbus_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [4:0] cmd_terms,
  output logic [4:0] virtual_terminal
);
  // ==========================================================================
  // Terminal levels follow the commanded pattern on the next cyclic refresh.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      virtual_terminal <= 5'h00;
    end else begin
      virtual_terminal <= cmd_terms;
    end
  end
endmodule : msv_fieldbus_model

// *** tb/msv_multi_speed_vf_asserts.sv ***
// Checker with concurrent assertions on the ports of the multi-speed block.
`timescale 1ns/1ps
module msv_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [4:0] virtual_terminal,
  input wire logic forward_run,
  input wire logic reverse_run,
  input wire logic [15:0] freq_cmd,
  input wire logic [3:0] speed_index,
  input wire logic multi_speed_active,
  input wire logic [9:0] voltage_cmd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Register bus answers.
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait cycle");
  property p_wait_short; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_short: assert property (p_wait_short) else $error("answer longer than one cycle");
  property p_no_spurious; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  property p_rdata_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");
  // ==========================================================================
  // Speed and voltage outputs.
  property p_active; 1'b1 |-> multi_speed_active == (speed_index != 4'h0); endproperty
  a_active: assert property (p_active) else $error("active flag disagrees with speed index");
  property p_none_zero; speed_index == 4'h0 |-> freq_cmd == 16'h0000; endproperty
  a_none_zero: assert property (p_none_zero) else $error("frequency without selected speed");
  property p_valid; speed_index != 4'h0 |-> freq_cmd != msv_pkg::FREQ_INVALID; endproperty
  a_valid: assert property (p_valid) else $error("invalid preset used as frequency");
  property p_vmax; voltage_cmd <= 10'h3e8; endproperty
  a_vmax: assert property (p_vmax) else $error("voltage above full scale");
  property p_hold;
    (!avs_write && $stable(virtual_terminal) && $stable(forward_run) && $stable(reverse_run)) [*2]
    |=> $stable(freq_cmd) && $stable(speed_index) && $stable(voltage_cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs changed with steady inputs");
  c_top: cover property (speed_index == 4'hf);
  c_low_ext: cover property (speed_index == 4'h3 && virtual_terminal[4]);
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule : msv_checker

// *** tb/tb.sv ***
// Self-checking testbench of the multi-speed and V/F pattern block.
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, multi_speed_active, forward_run = 1'b0, reverse_run = 1'b0;
  logic [4:0] cmd_terms = 5'h00, virtual_terminal;
  logic [15:0] freq_cmd;
  logic [3:0] speed_index;
  logic [9:0] voltage_cmd;
  int n_fail = 0, n_checks = 0;
  logic [8:0] rows [0:15] = '{9'h000, 9'h013, 9'h022, 9'h036, 9'h041, 9'h055, 9'h064, 9'h077,
                              9'h108, 9'h119, 9'h12a, 9'h13b, 9'h14c, 9'h15d, 9'h16e, 9'h17f};
  always #25 clock = ~clock;
  msv_multi_speed_vf msv_multi_speed_vf_inst (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .virtual_terminal(virtual_terminal),
    .forward_run(forward_run), .reverse_run(reverse_run), .freq_cmd(freq_cmd), .speed_index(speed_index),
    .multi_speed_active(multi_speed_active), .voltage_cmd(voltage_cmd));
  msv_fieldbus_model msv_fieldbus_model_inst (.clock(clock), .arst_n(arst_n), .cmd_terms(cmd_terms),
    .virtual_terminal(virtual_terminal));
  // ==========================================================================
  // Shared tasks and expectations.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task settle;
    repeat (4) @(posedge clock);
  endtask : settle
  task drive(input logic [4:0] t);
    cmd_terms <= t;
    settle;
  endtask : drive
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  function automatic logic [15:0] ef(input int n);
    return n == 0 ? 16'h0 : n == 1 ? msv_pkg::RST_HIGH_SPEED : n == 2 ? msv_pkg::RST_MIDDLE_SPEED :
           n == 3 ? msv_pkg::RST_LOW_SPEED : 16'(256 + 16 * n);
  endfunction : ef
  function automatic logic [31:0] vexp(input int f, input int base, input int b, input bit sq);
    int r;
    r = f * 1000 / base;
    if (r > 1000) r = 1000;
    if (sq) r = r * r / 1000;
    return 32'(b + r * (1000 - b) / 1000);
  endfunction : vexp
  function automatic logic [7:0] pa(input int n);
    return msv_pkg::OFS_PRESET_BASE + 8'(4 * n);
  endfunction : pa
  initial begin
    #2000000;
    n_fail++;
    conclude;
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(0, msv_pkg::OFS_LOAD_PATTERN, 0); chk("pattern", q, 32'h0);
    bus(0, msv_pkg::OFS_BASE_FREQ, 0); chk("base", q, 32'h258);
    for (int n = 1; n < 16; n++) begin
      bus(0, pa(n), 0); chk("preset", q, n < 4 ? 32'(ef(n)) : 32'(msv_pkg::FREQ_INVALID));
    end
    bus(0, 8'hfc, 0); chk("unmapped", q, 32'h0);
    $display("test reset done");
    for (int n = 4; n < 16; n++) bus(1, pa(n), 32'(ef(n)));
    for (int i = 0; i < 16; i++) begin
      drive(rows[i][8:4]);
      chk("speed", 32'(speed_index), 32'(rows[i][3:0]));
      chk("freq", 32'(freq_cmd), 32'(ef(int'(rows[i][3:0]))));
      chk("active", 32'(multi_speed_active), 32'(rows[i][3:0] != 4'h0));
    end
    $display("test table done");
    bus(1, pa(4), 32'(msv_pkg::FREQ_INVALID));
    bus(1, pa(8), 32'(msv_pkg::FREQ_INVALID));
    drive(5'h06); chk("mid wins", 32'(freq_cmd), 32'(ef(2)));
    drive(5'h10); chk("ext alone", 32'(speed_index), 32'h3);
    bus(1, pa(8), 32'(ef(8)));
    $display("test fallback done");
    drive(5'h02); chk("linear", 32'(voltage_cmd), vexp(300, 600, 60, 0));
    bus(1, msv_pkg::OFS_LOAD_PATTERN, 1); settle; chk("square", 32'(voltage_cmd), vexp(300, 600, 60, 1));
    bus(1, msv_pkg::OFS_LOAD_PATTERN, 2); reverse_run <= 1'b1; settle;
    chk("p2 rev", 32'(voltage_cmd), vexp(300, 600, 0, 0));
    forward_run <= 1'b1; reverse_run <= 1'b0; settle;
    chk("p2 fwd", 32'(voltage_cmd), vexp(300, 600, 60, 0));
    bus(1, msv_pkg::OFS_LOAD_PATTERN, 3); settle; chk("p3 fwd", 32'(voltage_cmd), vexp(300, 600, 0, 0));
    forward_run <= 1'b0; reverse_run <= 1'b1; settle;
    chk("p3 rev", 32'(voltage_cmd), vexp(300, 600, 60, 0));
    bus(1, msv_pkg::OFS_SECOND_BOOST, 100); drive(5'h0a);
    chk("second", 32'(voltage_cmd), vexp(300, 600, 100, 0));
    drive(5'h02); bus(1, msv_pkg::OFS_LOAD_PATTERN, 1);
    for (int m = 1; m < 3; m++) begin
      bus(1, msv_pkg::OFS_CONTROL_MODE, m); settle; chk("flux", 32'(voltage_cmd), vexp(300, 600, 60, 0));
    end
    bus(1, msv_pkg::OFS_CONTROL_MODE, 0); bus(1, msv_pkg::OFS_LOAD_PATTERN, 0); bus(1, msv_pkg::OFS_BASE_FREQ, 300);
    settle; chk("knee", 32'(voltage_cmd), 32'h3e8);
    bus(0, msv_pkg::OFS_VOLTAGE, 0);
    chk("volt reg", q, 32'h3e8);
    $display("test pattern done");
    bus(1, msv_pkg::OFS_USER_GROUP, 1); bus(0, pa(8), 0); chk("hidden", q, 32'h0);
    bus(1, msv_pkg::OFS_LOAD_PATTERN, 3); bus(1, msv_pkg::OFS_USER_GROUP, 0);
    bus(0, msv_pkg::OFS_LOAD_PATTERN, 0); chk("locked", q, 32'h0);
    bus(1, msv_pkg::OFS_PARAM_WRITE, 32'(msv_pkg::PWS_LOCKED)); bus(1, pa(1), 32'h1f4);
    bus(0, pa(1), 0); chk("preset wr", q, 32'h1f4);
    bus(1, msv_pkg::OFS_LOAD_PATTERN, 1); bus(0, msv_pkg::OFS_LOAD_PATTERN, 0); chk("pws", q, 32'h0);
    bus(1, msv_pkg::OFS_PARAM_WRITE, 0);
    $display("test access done");
    bus(1, msv_pkg::OFS_INPUT_ASSIGN, 32'h23018);
    drive(5'h01); chk("ext t0", 32'(speed_index), 32'h8);
    drive(5'h10); chk("high t4", 32'(speed_index), 32'h1);
    drive(5'h04); chk("low t2", 32'(speed_index), 32'h3);
    bus(1, msv_pkg::OFS_REMOTE_FUNC, 1); drive(5'h02); chk("remote", 32'(speed_index), 32'h0);
    bus(1, msv_pkg::OFS_REMOTE_FUNC, 0); settle; chk("local", 32'(speed_index), 32'h2);
    bus(0, msv_pkg::OFS_STATUS, 0);
    chk("status", q, {11'h0, 1'b1, 4'h2, ef(2)});
    $display("test assign done");
    bus(1, msv_pkg::OFS_LOAD_PATTERN, 2);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk("rst wait", 32'(avs_waitrequest), 32'h1);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(0, msv_pkg::OFS_LOAD_PATTERN, 0); chk("pattern", q, 32'h0);
    $display("test rerun reset done");
    conclude;
  end
endmodule : tb
bind msv_multi_speed_vf msv_checker msv_checker_inst (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .virtual_terminal(virtual_terminal),
  .forward_run(forward_run), .reverse_run(reverse_run), .freq_cmd(freq_cmd), .speed_index(speed_index),
  .multi_speed_active(multi_speed_active), .voltage_cmd(voltage_cmd));
